// *** hw/tpi_pkg.sv ***
package tpi_pkg;
	// Port addresses on the two select lines
	localparam logic [1:0] ADDR_CH0   = 2'h0;
	localparam logic [1:0] ADDR_CH1   = 2'h1;
	localparam logic [1:0] ADDR_CH2   = 2'h2;
	localparam logic [1:0] ADDR_SETUP = 2'h3;

	// Setup word field positions
	localparam int CHAN_PICK_HI_POS  = 7;
	localparam int CHAN_PICK_LO_POS  = 6;
	localparam int FMT_HI_POS        = 5;
	localparam int FMT_LO_POS        = 4;
	localparam int MODE_HI_POS       = 3;
	localparam int MODE_LO_POS       = 1;
	localparam int DECIMAL_POS       = 0;

	localparam logic [1:0] PICK_READBACK = 2'h3;

	typedef enum logic [1:0] {
		TPI_FMT_LATCH = 2'b00,
		TPI_FMT_LOW   = 2'b01,
		TPI_FMT_HIGH  = 2'b10,
		TPI_FMT_BOTH  = 2'b11
	} tpi_fmt_t;

	// Reset values of per-channel state
	localparam logic [7:0]  SETUP_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [2:0]  MODE_RST  = 3'h0;
endpackage

// *** hw/tpi_strobe.sv ***
// Turns a low-active write strobe into a one-cycle pulse on its falling edge
module tpi_strobe (
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	input  wire logic strobe_n_in,
	output logic      pulse_out
);
	logic prev_reg;
	logic prev_next;

	// Remember last level so a long strobe yields one pulse only
	always_comb begin
		prev_next = strobe_n_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign pulse_out = prev_reg & ~strobe_n_in;
endmodule

// *** hw/tpi_channel.sv ***
// One channel's programming state: format, mode, count holding register
module tpi_channel (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        setup_we_in,
	input  wire logic        count_we_in,
	input  wire logic [7:0]  data_in,
	output logic [1:0]       fmt_out,
	output logic [2:0]       mode_out,
	output logic             decimal_out,
	output logic [15:0]      count_out,
	output logic             programmed_out,
	output logic             load_out,
	output logic             hi_next_out
);
	logic [7:0]  setup_reg,  setup_next;
	logic [15:0] count_reg,  count_next;
	logic        hi_reg,     hi_next;
	logic        prog_reg,   prog_next;
	logic        load_reg,   load_next;
	logic [1:0]  fmt_w;

	assign fmt_w = setup_reg[tpi_pkg::FMT_HI_POS:tpi_pkg::FMT_LO_POS];

	// Setup word, byte pointer and holding register update
	always_comb begin
		setup_next = setup_reg;
		count_next = count_reg;
		hi_next    = hi_reg;
		prog_next  = prog_reg;
		load_next  = 1'b0;
		if (setup_we_in) begin
			setup_next = data_in;
			count_next = tpi_pkg::COUNT_RST;
			hi_next    = 1'b0;
			prog_next  = 1'b1;
		end else if (count_we_in && prog_reg) begin
			// Mode stays; only the count and the byte pointer change
			unique case (fmt_w)
				tpi_pkg::TPI_FMT_LOW: begin
					count_next[7:0] = data_in;
					load_next       = 1'b1;
				end
				tpi_pkg::TPI_FMT_HIGH: begin
					count_next[15:8] = data_in;
					load_next        = 1'b1;
				end
				tpi_pkg::TPI_FMT_BOTH: begin
					if (hi_reg) begin
						count_next[15:8] = data_in;
						load_next        = 1'b1;
					end else begin
						count_next[7:0] = data_in;
					end
					hi_next = ~hi_reg;
				end
				tpi_pkg::TPI_FMT_LATCH: begin
					load_next = 1'b0; // Latch format never stored
				end
			endcase
		end
	end

	// Undefined content before programming is fine, but we still reset
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			setup_reg <= tpi_pkg::SETUP_RST;
			count_reg <= tpi_pkg::COUNT_RST;
			hi_reg    <= 1'b0;
			prog_reg  <= 1'b0;
			load_reg  <= 1'b0;
		end else begin
			setup_reg <= setup_next;
			count_reg <= count_next;
			hi_reg    <= hi_next;
			prog_reg  <= prog_next;
			load_reg  <= load_next;
		end
	end

	// Modes 2 and 3 ignore the top mode bit
	always_comb begin
		mode_out = setup_reg[tpi_pkg::MODE_HI_POS:tpi_pkg::MODE_LO_POS];
		if (mode_out[1]) begin
			mode_out[2] = 1'b0;
		end
	end

	assign fmt_out        = fmt_w;
	assign decimal_out    = setup_reg[tpi_pkg::DECIMAL_POS];
	assign count_out      = count_reg;
	assign programmed_out = prog_reg;
	assign load_out       = load_reg;
	assign hi_next_out    = hi_reg;
endmodule

// *** hw/tpi_top.sv ***
// Function
// - A write with both select lines high is stored as the setup word, unless it is a read-back or latch-format word.
// - Setup bits 7:6 pick channel 0..2; value 3 is read-back, not a channel.
// - Setup bits 5:4 give format: latch, low only, high only, low then high.
// - Count bytes follow the channel format; device places bytes accordingly.
// - Count bytes land only at the channel's own address, never setup.
// - A new count may come any time and leaves the mode untouched.
// - Nothing is guaranteed about a channel until it is programmed.
// - Writes to different channels interleave freely with separate byte pointers.
// - Strobes are ignored unless the low-active chip select is low.
// - Selects decode 00,01,10 to channels 0..2 and 11 to setup.
// - A setup word clears both bytes of the channel's holding register.
module tpi_top (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        chip_sel_n_in,
	input  wire logic        rd_n_in,
	input  wire logic        wr_n_in,
	input  wire logic        port_sel_hi_in,
	input  wire logic        port_sel_lo_in,
	input  wire logic [7:0]  data_in,
	output logic [7:0]       data_out,
	output logic             data_oe_out,
	output logic [47:0]      count_holding_reg_out,
	output logic [8:0]       op_mode_out,
	output logic [5:0]       byte_format_out,
	output logic [2:0]       decimal_out,
	output logic [2:0]       programmed_out,
	output logic [2:0]       count_load_out
);
	logic        wr_pulse;
	logic [1:0]  addr_w;
	logic        wr_ok;
	logic [2:0]  setup_we;
	logic [2:0]  count_we;
	logic [1:0]  fmt_w   [3];
	logic [2:0]  mode_w  [3];
	logic        dec_w   [3];
	logic [15:0] cnt_w   [3];
	logic        prog_w  [3];
	logic        load_w  [3];
	logic        hi_w    [3];
	logic [7:0]  rdata_reg, rdata_next;
	logic        oe_reg,    oe_next;
	logic [47:0] cnt_reg,   cnt_next;
	logic [8:0]  mode_reg,  mode_next;
	logic [5:0]  fmt_reg,   fmt_next;
	logic [2:0]  dec_reg,   dec_next;
	logic [2:0]  prog_reg,  prog_next;
	logic [2:0]  load_reg,  load_next;

	// Strobe edge: data is taken once per write cycle
	tpi_strobe u_wr (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.strobe_n_in (wr_n_in),
		.pulse_out   (wr_pulse)
	);

	assign addr_w = {port_sel_hi_in, port_sel_lo_in};
	assign wr_ok  = wr_pulse & ~chip_sel_n_in;

	// Address and setup-word decode to per-channel write enables
	always_comb begin
		setup_we = 3'h0;
		count_we = 3'h0;
		if (wr_ok) begin
			if (addr_w == tpi_pkg::ADDR_SETUP) begin
				// Latch format and read-back are commands, not programming
				if (data_in[tpi_pkg::CHAN_PICK_HI_POS:tpi_pkg::CHAN_PICK_LO_POS] != tpi_pkg::PICK_READBACK &&
				    data_in[tpi_pkg::FMT_HI_POS:tpi_pkg::FMT_LO_POS] != tpi_pkg::TPI_FMT_LATCH) begin
					setup_we[data_in[tpi_pkg::CHAN_PICK_HI_POS:tpi_pkg::CHAN_PICK_LO_POS]] = 1'b1;
				end
			end else begin
				count_we[addr_w] = 1'b1;
			end
		end
	end

	// Independent channels keep their own byte pointers
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			tpi_channel u_ch (
				.core_clk_in    (core_clk_in),
				.rst_in         (rst_in),
				.setup_we_in    (setup_we[g]),
				.count_we_in    (count_we[g]),
				.data_in        (data_in),
				.fmt_out        (fmt_w[g]),
				.mode_out       (mode_w[g]),
				.decimal_out    (dec_w[g]),
				.count_out      (cnt_w[g]),
				.programmed_out (prog_w[g]),
				.load_out       (load_w[g]),
				.hi_next_out    (hi_w[g])
			);
		end
	endgenerate

	// Output registering; readback of the holding register is a simple view,
	// live counting-element reads are left to the counting logic.
	always_comb begin
		rdata_next = 8'h00;
		oe_next    = 1'b0;
		if (~chip_sel_n_in && ~rd_n_in && addr_w != tpi_pkg::ADDR_SETUP) begin
			oe_next    = 1'b1;
			rdata_next = hi_w[addr_w] ? cnt_w[addr_w][15:8] : cnt_w[addr_w][7:0];
		end
		cnt_next  = {cnt_w[2], cnt_w[1], cnt_w[0]};
		mode_next = {mode_w[2], mode_w[1], mode_w[0]};
		fmt_next  = {fmt_w[2], fmt_w[1], fmt_w[0]};
		dec_next  = {dec_w[2], dec_w[1], dec_w[0]};
		prog_next = {prog_w[2], prog_w[1], prog_w[0]};
		load_next = {load_w[2], load_w[1], load_w[0]};
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_reg <= 8'h00;
			oe_reg    <= 1'b0;
			cnt_reg   <= 48'h000000000000;
			mode_reg  <= 9'h000;
			fmt_reg   <= 6'h00;
			dec_reg   <= 3'h0;
			prog_reg  <= 3'h0;
			load_reg  <= 3'h0;
		end else begin
			rdata_reg <= rdata_next;
			oe_reg    <= oe_next;
			cnt_reg   <= cnt_next;
			mode_reg  <= mode_next;
			fmt_reg   <= fmt_next;
			dec_reg   <= dec_next;
			prog_reg  <= prog_next;
			load_reg  <= load_next;
		end
	end

	assign data_out              = rdata_reg;
	assign data_oe_out           = oe_reg;
	assign count_holding_reg_out = cnt_reg;
	assign op_mode_out           = mode_reg;
	assign byte_format_out       = fmt_reg;
	assign decimal_out           = dec_reg;
	assign programmed_out        = prog_reg;
	assign count_load_out        = load_reg;
endmodule

// *** sim/tpi_top_chk.sv ***
module tpi_chk (
	input wire logic	core_clk_in,
	input wire logic	rst_in,
	input wire logic	chip_sel_n_in,
	input wire logic	wr_n_in,
	input wire logic	rd_n_in,
	input wire logic	port_sel_hi_in,
	input wire logic	port_sel_lo_in,
	input wire logic [7:0]	data_in,
	input wire logic [47:0]	count_holding_reg_out,
	input wire logic [8:0]	op_mode_out,
	input wire logic [5:0]	byte_format_out,
	input wire logic [2:0]	count_load_out,
	input wire logic	data_oe_out
);
	logic		wr_q, t1, t2, t3, ok, rd_q;
	logic [7:0]	d1, d2, d3;
	logic [1:0]	a1, a2, a3, c;
	// Pipeline each take so outputs are judged once they have settled
	always_ff @(posedge core_clk_in) begin
		wr_q <= rst_in | wr_n_in;
		t1 <= !rst_in && !chip_sel_n_in && !wr_n_in && wr_q;
		t2 <= !rst_in && t1;
		t3 <= !rst_in && t2;
		rd_q <= !rst_in && !chip_sel_n_in && !rd_n_in && {port_sel_hi_in, port_sel_lo_in} != 2'h3;
		d1 <= data_in;
		d2 <= d1;
		d3 <= d2;
		a1 <= {port_sel_hi_in, port_sel_lo_in};
		a2 <= a1;
		a3 <= a2;
	end
	assign c = d3[7:6];
	assign ok = t3 && a3 == 2'h3 && c != 2'h3 && d3[5:4] != 2'h0;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_setup_sets_fmt: assert property (ok |-> byte_format_out[c*2+:2] == d3[5:4]) else $error("format wrong");
	a_setup_clears: assert property (ok |-> count_holding_reg_out[c*16+:16] == 16'h0000) else $error("count kept");
	a_setup_mode: assert property (ok |-> op_mode_out[c*3+:3] == (d3[2] ? {1'h0, d3[2:1]} : d3[3:1]))
		else $error("mode wrong");
	// Registered outputs move one edge after the take, so t2 lines up with that change
	a_load_cause: assert property (count_load_out != 3'h0 |-> t2 && a2 != 2'h3) else $error("stray load");
	a_count_quiet: assert property (!t2 |-> $stable(count_holding_reg_out)) else $error("count moved");
	a_count_keeps_mode: assert property (t2 && a2 != 2'h3 |-> $stable(op_mode_out) && $stable(byte_format_out))
		else $error("mode moved");
	a_low_byte: assert property (t3 && a3 != 2'h3 && byte_format_out[a3*2+:2] == 2'h1
		|-> count_holding_reg_out[a3*16+:8] == d3) else $error("low byte");
	a_single_load: assert property (count_load_out != 3'h0 |=> count_load_out == 3'h0) else $error("long load");
	a_oe_follows_sel: assert property (data_oe_out == rd_q) else $error("read enable wrong");
endmodule

bind tpi_top tpi_chk i_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .chip_sel_n_in(chip_sel_n_in),
	.wr_n_in(wr_n_in), .port_sel_hi_in(port_sel_hi_in), .port_sel_lo_in(port_sel_lo_in), .data_in(data_in),
	.count_holding_reg_out(count_holding_reg_out), .op_mode_out(op_mode_out),
	.byte_format_out(byte_format_out), .count_load_out(count_load_out), .rd_n_in(rd_n_in),
	.data_oe_out(data_oe_out));

// *** sim/tpi_host.sv ***
module tpi_host (
	input  wire logic	core_clk_in,
	output logic		cs_n_out,
	output logic		wr_n_out,
	output logic [1:0]	sel_out,
	output logic [7:0]	data_out,
	output logic		rd_n_out,
	input  wire logic [7:0]	rdata_in,
	input  wire logic	oe_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n_out = 1'h1;
		wr_n_out = 1'h1;
		rd_n_out = 1'h1;
		sel_out = 2'h0;
		data_out = 8'h00;
	end
	// One write, held whole across the take edge; returns on the release edge so the
	// one-cycle load pulse is still standing when the caller looks
	task automatic wr(input logic cs_n, input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		cs_n_out <= cs_n;
		sel_out <= a;
		data_out <= d;
		wr_n_out <= 1'h0;
		repeat (2) @(posedge core_clk_in);
		cs_n_out <= 1'h1;
		wr_n_out <= 1'h1;
		data_out <= ~d; // Released bus must not keep showing the last byte
	endtask
	// One read: the design registers the byte at the edge that sees the strobe low
	task automatic rd(input logic cs_n, input logic [1:0] a, output logic [8:0] q);
		@(posedge core_clk_in);
		cs_n_out <= cs_n;
		sel_out <= a;
		rd_n_out <= 1'h0;
		@(posedge core_clk_in);
		cs_n_out <= 1'h1;
		rd_n_out <= 1'h1;
		#1;
		q = {oe_in, rdata_in};
	endtask
endmodule

// *** sim/test_tpi_top.sv ***
module test_tpi_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic		core_clk_in = 1'h0;
	logic		rst_in = 1'h1;
	logic		cs_n, wr_n, rd_n, data_oe_out;
	logic [1:0]	sel;
	logic [7:0]	d, data_out;
	logic [47:0]	count_holding_reg_out;
	logic [8:0]	op_mode_out;
	logic [5:0]	byte_format_out;
	logic [2:0]	decimal_out, programmed_out, count_load_out;
	logic [15:0]	m_cnt [3];
	logic [2:0]	m_mode [3];
	logic [1:0]	m_fmt [3];
	logic		m_dec [3], m_prog [3], m_ptr [3];
	int		failures = 0, n_tests = 0;
	tpi_host i_host (.core_clk_in(core_clk_in), .cs_n_out(cs_n), .wr_n_out(wr_n), .sel_out(sel), .data_out(d),
		.rd_n_out(rd_n), .rdata_in(data_out), .oe_in(data_oe_out));
	// Host model drives both strobes; reads follow every write
	tpi_top i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .chip_sel_n_in(cs_n), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .port_sel_hi_in(sel[1]), .port_sel_lo_in(sel[0]), .data_in(d),
		.data_out(data_out), .data_oe_out(data_oe_out), .count_holding_reg_out(count_holding_reg_out),
		.op_mode_out(op_mode_out), .byte_format_out(byte_format_out), .decimal_out(decimal_out),
		.programmed_out(programmed_out), .count_load_out(count_load_out));
	initial begin
		forever #4 core_clk_in = ~core_clk_in;
	end
	// Modes 2 and 3 ignore the top mode bit
	function automatic logic [2:0] exp_mode(input logic [7:0] w);
		return w[2] ? {1'h0, w[2:1]} : w[3:1];
	endfunction
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_tests++;
		if (e !== g) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_all();
		logic [47:0]	ec;
		logic [8:0]	em;
		logic [5:0]	ef;
		logic [2:0]	ed, ep;
		for (int i = 0; i < 3; i++) begin
			ec[i*16+:16] = m_cnt[i];
			em[i*3+:3] = m_mode[i];
			ef[i*2+:2] = m_fmt[i];
			ed[i] = m_dec[i];
			ep[i] = m_prog[i];
		end
		chk("count", ec, count_holding_reg_out);
		chk("mode", em, op_mode_out);
		chk("format", ef, byte_format_out);
		chk("decimal", ed, decimal_out);
		chk("programmed", ep, programmed_out);
	endtask
	// Update the expected state, perform the write, compare everything
	task automatic step(input logic cs_n_v, input logic [1:0] a, input logic [7:0] w);
		logic [1:0]	ch;
		logic		ld;
		logic [8:0]	q, eq;
		ch = (a == 2'h3) ? w[7:6] : a;
		ld = 1'h0;
		if (!cs_n_v && a == 2'h3 && ch != 2'h3 && w[5:4] != 2'h0) begin
			m_fmt[ch] = w[5:4];
			m_mode[ch] = exp_mode(w);
			m_dec[ch] = w[0];
			m_prog[ch] = 1'h1;
			m_cnt[ch] = 16'h0000;
			m_ptr[ch] = 1'h0;
		end else if (!cs_n_v && a != 2'h3 && m_prog[ch]) begin
			if (m_fmt[ch] == 2'h2 || (m_fmt[ch] == 2'h3 && m_ptr[ch])) m_cnt[ch][15:8] = w;
			else m_cnt[ch][7:0] = w;
			ld = m_fmt[ch] != 2'h3 || m_ptr[ch];
			m_ptr[ch] = m_fmt[ch] == 2'h3 && !m_ptr[ch];
		end
		i_host.wr(cs_n_v, a, w);
		#1;
		chk("load", 3'(ld) << ch, count_load_out);
		cmp_all();
		// Read back the byte at the channel's pointer; deselected or setup reads drive nothing
		eq = 9'h000;
		if (!cs_n_v && a != 2'h3) eq = {1'h1, m_ptr[ch] ? m_cnt[ch][15:8] : m_cnt[ch][7:0]};
		i_host.rd(cs_n_v, a, q);
		chk("read", eq, q);
	endtask
	task automatic conclude();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Corner writes: unprogrammed count, deselected setup, walk, every format, refused words
	logic [10:0] tbl [11] = '{11'h055, 11'h730, 11'h330, 11'h034, 11'h012, 11'h354, 11'h3A7,
		11'h1C3, 11'h2E5, 11'h3F6, 11'h306};
	initial begin
		for (int i = 0; i < 3; i++) begin
			m_cnt[i] = 16'h0000;
			m_mode[i] = 3'h0;
			m_fmt[i] = 2'h0;
			m_dec[i] = 1'h0;
			m_prog[i] = 1'h0;
			m_ptr[i] = 1'h0;
		end
		repeat (12) @(posedge core_clk_in);
		rst_in <= 1'h0;
		void'($urandom(87));
		#1;
		cmp_all();
		$display("test reset done");
		foreach (tbl[i]) step(tbl[i][10], tbl[i][9:8], tbl[i][7:0]);
		$display("test corners done");
		repeat (200) step($urandom_range(7) == 0, 2'($urandom), 8'($urandom));
		$display("test random done");
		conclude();
	end
	initial begin
		repeat (20000) @(posedge core_clk_in);
		failures++;
		conclude();
	end
endmodule
